//--- rtl/alarm_second_regs.sv
/*
  Drop bus one-second alarm status: per-source one-second and
  persistent trackers, pulse watchdog, AHB-Lite register slave and a
  maskable interrupt for interval and pulse-loss events.
  Assumes alarm sources are levels on clock; the one-second pulse is an
  asynchronous pin; a single AHB-Lite master drives the slave port.
*/
`timescale 1ns/10ps
`include "alarm_second_consts.svh"
module alarm_second_regs import alarm_second_pkg::*; #(
  parameter int TICK_TIMEOUT_CYCLES = `TICK_TIMEOUT_NS / `CLOCK_PERIOD_NS,
  parameter int SLOTS = 3
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rstn,
  // One-second pulse pin
  input wire logic one_second_pulse,
  // Alarm sources
  input wire alarm_in_s alarms,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Interrupt
  output logic irq
);

  // Pulse sampling and edge detection
  logic pulse_sync;
  logic pulse_last;
  logic tick;

  level_sync #(
    .WIDTH(1)
  ) u_pulse_sync (
    .clock(clock),
    .rstn(rstn),
    .async_in(one_second_pulse),
    .sync_out(pulse_sync)
  );

  always_ff @(posedge clock) begin
    if (!rstn) begin
      pulse_last <= 1'b0;
    end else begin
      pulse_last <= pulse_sync;
    end
  end

  assign tick = pulse_sync & ~pulse_last;

  // Pulse watchdog
  pulse_state_e pulse_state;
  pulse_state_e next_pulse_state;
  logic [31:0] idle_count;
  logic [31:0] next_idle_count;
  logic timeout;
  logic lost_event;

  assign timeout = (idle_count >= 32'(TICK_TIMEOUT_CYCLES - 1));
  assign next_idle_count = tick ? 32'h0 : (timeout ? idle_count : idle_count + 32'h1);

  always_comb begin
    next_pulse_state = pulse_state;
    unique case (pulse_state)
      PULSE_ABSENT: begin
        if (tick) begin
          next_pulse_state = PULSE_PRESENT;
        end
      end
      PULSE_PRESENT: begin
        if (timeout && !tick) begin
          next_pulse_state = PULSE_ABSENT;
        end
      end
    endcase
  end

  assign lost_event = (pulse_state == PULSE_PRESENT) && (next_pulse_state == PULSE_ABSENT);

  always_ff @(posedge clock) begin
    if (!rstn) begin
      pulse_state <= PULSE_ABSENT;
      idle_count <= 32'h0;
    end else begin
      pulse_state <= next_pulse_state;
      idle_count <= next_idle_count;
    end
  end

  // Control register
  control_reg_s control;
  logic pulse_ok;
  logic [SLOTS-1:0] slot_enable;

  assign pulse_ok = (pulse_state == PULSE_PRESENT) || tick;

  // Slot 1 carries the VC-4 in VC-4 mode; slots 2 and 3 then idle
  genvar s;
  generate
    for (s = 0; s < SLOTS; s++) begin : g_slot_en
      if (s == 0) begin : g_first
        assign slot_enable[s] = pulse_ok;
      end else begin : g_other
        assign slot_enable[s] = pulse_ok & ~control.vc4_mode;
      end
    end
  endgenerate

  // Trackers
  logic [SLOTS-1:0] sec_oom;
  logic [SLOTS-1:0] sec_lom;
  logic [SLOTS-1:0] persist_ais;
  logic persist_par;
  logic persist_loc;

  generate
    for (s = 0; s < SLOTS; s++) begin : g_track
      second_tracker u_oom (
        .clock(clock),
        .rstn(rstn),
        .alarm(alarms.oom[s]),
        .tick(tick),
        .enable(slot_enable[s]),
        .sec_alarm(sec_oom[s]),
        .persist_alarm()
      );
      second_tracker u_lom (
        .clock(clock),
        .rstn(rstn),
        .alarm(alarms.lom[s]),
        .tick(tick),
        .enable(slot_enable[s]),
        .sec_alarm(sec_lom[s]),
        .persist_alarm()
      );
      second_tracker u_ais (
        .clock(clock),
        .rstn(rstn),
        .alarm(alarms.upstream_ais[s]),
        .tick(tick),
        .enable(slot_enable[s]),
        .sec_alarm(),
        .persist_alarm(persist_ais[s])
      );
    end
  endgenerate

  second_tracker u_par (
    .clock(clock),
    .rstn(rstn),
    .alarm(alarms.parity),
    .tick(tick),
    .enable(pulse_ok),
    .sec_alarm(),
    .persist_alarm(persist_par)
  );

  second_tracker u_loc (
    .clock(clock),
    .rstn(rstn),
    .alarm(alarms.clock_loss),
    .tick(tick),
    .enable(pulse_ok),
    .sec_alarm(),
    .persist_alarm(persist_loc)
  );

  // Register views
  sec_h4_reg_s sec_view;
  persist_reg_s persist_view;

  assign sec_view.unused = '0;
  assign sec_view.sec_oom = sec_oom;
  assign sec_view.sec_lom = sec_lom;
  assign persist_view.unused = '0;
  assign persist_view.persist_upstream_ais = persist_ais;
  assign persist_view.persist_drop_parity = persist_par;
  assign persist_view.persist_drop_clock_loss = persist_loc;

  // AHB address phase decode
  logic addr_valid;
  logic addr_mapped;
  logic [7:0] addr_index;

  assign addr_valid = hsel && hready && (htrans == `HTRANS_NONSEQ || htrans == `HTRANS_SEQ);
  assign addr_index = haddr[9:2];
  assign addr_mapped = (haddr[31:10] == 22'h0) && (haddr[1:0] == 2'h0);

  // Data phase write state
  logic wr_pending;
  logic [7:0] wr_index;

  always_ff @(posedge clock) begin
    if (!rstn) begin
      wr_pending <= 1'b0;
      wr_index <= 8'h00;
    end else begin
      wr_pending <= addr_valid && hwrite && addr_mapped;
      wr_index <= addr_valid ? addr_index : wr_index;
    end
  end

  wire wr_control = wr_pending && (wr_index == `IDX_CONTROL);
  wire wr_status = wr_pending && (wr_index == `IDX_IRQ_STATUS);
  wire wr_mask = wr_pending && (wr_index == `IDX_IRQ_MASK);

  // Writes to the one-second registers decode to nothing
  always_ff @(posedge clock) begin
    if (!rstn) begin
      control <= control_reg_s'(`CONTROL_RESET);
    end else if (wr_control) begin
      control <= control_reg_s'({7'h00, hwdata[0]});
    end
  end

  // Interrupt status, mask and output
  irq_reg_s irq_status;
  irq_reg_s irq_mask;
  irq_reg_s irq_set;
  irq_reg_s irq_clear;
  irq_reg_s next_irq_status;

  // Only interval and pulse-loss events are wired; alarm bits never are
  assign irq_set.unused = '0;
  assign irq_set.interval_done = tick;
  assign irq_set.pulse_lost = lost_event;
  assign irq_clear = wr_status ? irq_reg_s'(hwdata[7:0]) : irq_reg_s'(8'h00);
  assign next_irq_status = (irq_status & ~irq_clear) | irq_set;

  always_ff @(posedge clock) begin
    if (!rstn) begin
      irq_status <= '0;
    end else begin
      irq_status <= next_irq_status;
    end
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      irq_mask <= irq_reg_s'(`IRQ_MASK_RESET);
    end else if (wr_mask) begin
      irq_mask <= irq_reg_s'({6'h00, hwdata[1:0]});
    end
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(next_irq_status & irq_mask);
    end
  end

  // Read data, registered at the address phase
  logic [7:0] rd_byte;

  assign rd_byte = !addr_mapped ? 8'h00 :
                   (addr_index == `IDX_SEC_H4) ? sec_view :
                   (addr_index == `IDX_PERSIST) ? persist_view :
                   (addr_index == `IDX_CONTROL) ? control :
                   (addr_index == `IDX_IRQ_STATUS) ? irq_status :
                   (addr_index == `IDX_IRQ_MASK) ? irq_mask : 8'h00;

  always_ff @(posedge clock) begin
    if (!rstn) begin
      hrdata <= 32'h0;
    end else if (addr_valid && !hwrite) begin
      hrdata <= {24'h000000, rd_byte};
    end
  end

  // Zero wait states, always OKAY
  assign hreadyout = 1'b1;
  assign hresp = `HRESP_OKAY;

endmodule

//--- pkg/alarm_second_consts.svh
/*
  Constants for the drop bus one-second alarm status block: register
  indices, timing figures and bus encodings.
  Assumes it is included by bare name by every file that needs a figure.
*/
// Notes on behaviour
// - Second bit: changed in interval, or one
// - No one-second pulse: every bit inactive
// - One-second bits never raise an interrupt
// - Persistent: active, not risen previous interval
// - H4 register: OOM bits 5-3, LOM 2-0
// - Persistent register: AIS 4-2, parity, clock
// - Slot 1 also covers the VC-4
`ifndef ALARM_SECOND_CONSTS_SVH
`define ALARM_SECOND_CONSTS_SVH

// Register indices; byte address is four times the index
`define IDX_SEC_H4 8'h65
`define IDX_PERSIST 8'h66
`define IDX_CONTROL 8'h70
`define IDX_IRQ_STATUS 8'h71
`define IDX_IRQ_MASK 8'h72

// Reset values
`define CONTROL_RESET 8'h00
`define IRQ_MASK_RESET 8'h00

// Pulse watchdog: no pulse for this long means the pulse is absent
`define TICK_TIMEOUT_NS 1250000000
`define CLOCK_PERIOD_NS 40

// AHB-Lite encodings
`define HTRANS_NONSEQ 2'h2
`define HTRANS_SEQ 2'h3
`define HSIZE_WORD 3'h2
`define HRESP_OKAY 1'h0

`endif

//--- pkg/alarm_second_pkg.sv
/*
  Types for the drop bus one-second alarm status block: alarm source
  bundle, register layouts and the pulse presence state.
  Assumes the constants header is included where figures are needed.
*/
package alarm_second_pkg;

  // Raw alarm levels from the drop bus detectors, slot 1 in bit 0
  typedef struct packed {
    logic [2:0] oom;
    logic [2:0] lom;
    logic [2:0] upstream_ais;
    logic parity;
    logic clock_loss;
  } alarm_in_s;

  typedef struct packed {
    logic [1:0] unused;
    logic [2:0] sec_oom;
    logic [2:0] sec_lom;
  } sec_h4_reg_s;

  typedef struct packed {
    logic [2:0] unused;
    logic [2:0] persist_upstream_ais;
    logic persist_drop_parity;
    logic persist_drop_clock_loss;
  } persist_reg_s;

  typedef struct packed {
    logic [6:0] unused;
    logic vc4_mode;
  } control_reg_s;

  typedef struct packed {
    logic [5:0] unused;
    logic pulse_lost;
    logic interval_done;
  } irq_reg_s;

  typedef enum logic {
    PULSE_ABSENT = 1'b0,
    PULSE_PRESENT = 1'b1
  } pulse_state_e;

endpackage

//--- rtl/level_sync.sv
/*
  Two flip-flop synchroniser for asynchronous levels.
  Assumes the input may change at any time relative to clock.
*/
`timescale 1ns/10ps
module level_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rstn,
  // Levels
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] stage1;

  always_ff @(posedge clock) begin
    if (!rstn) begin
      stage1 <= '0;
      sync_out <= '0;
    end else begin
      stage1 <= async_in;
      sync_out <= stage1;
    end
  end

endmodule

//--- rtl/second_tracker.sv
/*
  Per-alarm one-second tracker: the one-second indication and the
  persistent one-second indication of a single alarm source.
  Assumes alarm is a level on clock and tick a one-cycle pulse.
*/
`timescale 1ns/10ps
module second_tracker (
  // Clock and reset
  input wire logic clock,
  input wire logic rstn,
  // Source and interval
  input wire logic alarm,
  input wire logic tick,
  input wire logic enable,
  // Indications
  output logic sec_alarm,
  output logic persist_alarm
);

  logic last;
  logic changed_cur;
  logic seen_cur;
  logic rose_cur;
  logic rose_prev;
  wire change_now = alarm ^ last;
  wire rise_now = alarm & ~last;

  always_ff @(posedge clock) begin
    if (!rstn) begin
      last <= 1'b0;
      changed_cur <= 1'b0;
      seen_cur <= 1'b0;
      rose_cur <= 1'b0;
      rose_prev <= 1'b0;
      sec_alarm <= 1'b0;
      persist_alarm <= 1'b0;
    end else begin
      last <= alarm;
      if (!enable) begin
        changed_cur <= 1'b0;
        seen_cur <= 1'b0;
        rose_cur <= 1'b0;
        rose_prev <= 1'b0;
        sec_alarm <= 1'b0;
        persist_alarm <= 1'b0;
      end else if (tick) begin
        sec_alarm <= changed_cur | change_now | alarm;
        persist_alarm <= (seen_cur | alarm) & ~rose_prev;
        rose_prev <= rose_cur | rise_now;
        changed_cur <= 1'b0;
        seen_cur <= 1'b0;
        rose_cur <= 1'b0;
      end else begin
        changed_cur <= changed_cur | change_now;
        seen_cur <= seen_cur | alarm;
        rose_cur <= rose_cur | rise_now;
      end
    end
  end

endmodule

//--- dv/alarm_second_regs_properties.sv
/* Port checker for the one-second alarm status block.
   Assumes hready is tied to hreadyout and the pulse pin is seen on clock. */
`timescale 1ns/10ps
module alarm_second_checker #(
  parameter int TICK_TIMEOUT_CYCLES = 64
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rstn,
  // Pulse pin and bus
  input wire logic one_second_pulse,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] hrdata,
  input wire logic irq
);
  localparam int GAP_MAX = TICK_TIMEOUT_CYCLES + 8;
  int gap;
  logic pin_q;
  wire rd = hsel && hreadyout && htrans[1] && !hwrite;
  wire wr = hsel && hreadyout && htrans[1] && hwrite;
  wire alarm_rd = rd && (haddr == 32'h194 || haddr == 32'h198);
  // Cycles since the pin last rose; saturated means no pulse
  always_ff @(posedge clock) begin
    pin_q <= one_second_pulse;
    if (!rstn) gap <= GAP_MAX;
    else if (one_second_pulse && !pin_q) gap <= 0;
    else if (gap < GAP_MAX) gap <= gap + 1;
  end
  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);
  a_resp_okay: assert property (hresp == 1'b0) else $error("hresp not okay");
  a_ready_high: assert property (hreadyout == 1'b1) else $error("hreadyout low");
  a_h4_unused: assert property (rd && haddr == 32'h194 |=> hrdata[31:6] == '0)
    else $error("h4 unused bits set");
  a_persist_unused: assert property (rd && haddr == 32'h198 |=> hrdata[31:5] == '0)
    else $error("persist unused bits set");
  a_no_pulse_idle: assert property (alarm_rd && gap == GAP_MAX |=> hrdata == '0)
    else $error("alarm bits without pulse");
  a_rdata_hold: assert property (!rd |=> $stable(hrdata)) else $error("hrdata moved");
  a_irq_reset: assert property ($rose(rstn) |-> !irq) else $error("irq after reset");
  a_irq_cause: assert property ($rose(irq) |-> gap <= 8 || gap >= TICK_TIMEOUT_CYCLES ||
    $past(wr) || $past(wr, 2) || $past(wr, 3)) else $error("irq without event");
  c_irq: cover property ($rose(irq));
  c_h4_set: cover property (rd && haddr == 32'h194 ##1 hrdata[5:0] != '0);
  c_persist_set: cover property (rd && haddr == 32'h198 ##1 hrdata[4:0] != '0);
endmodule
bind alarm_second_regs alarm_second_checker #(.TICK_TIMEOUT_CYCLES(TICK_TIMEOUT_CYCLES)) alarm_second_checker_inst (
  .clock(clock), .rstn(rstn), .one_second_pulse(one_second_pulse), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .irq(irq));

//--- dv/tb_drop_bus_one_second_alarm_status.sv
/* Testbench for the one-second alarm status block.
   Assumes a single AHB-Lite master and a short pulse watchdog. */
`timescale 1ns/10ps
`include "alarm_second_consts.svh"
module tb_drop_bus_one_second_alarm_status import alarm_second_pkg::*;;
  localparam int TMO = 64;
  logic clock = 0, rstn = 0, one_second_pulse = 0, hsel = 0, hwrite = 0;
  logic hreadyout, hresp, irq;
  alarm_in_s alarms = '0;
  logic [31:0] haddr = '0, hwdata = '0, hrdata, q;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = `HSIZE_WORD;
  int err_total = 0, num_checks = 0;
  alarm_second_regs #(.TICK_TIMEOUT_CYCLES(TMO)) alarm_second_regs_inst (.clock(clock), .rstn(rstn),
    .one_second_pulse(one_second_pulse), .alarms(alarms), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .irq(irq));
  initial forever #20 clock = ~clock;
  task close_out;
    if (err_total == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task chk(input string n, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", n, exp, got);
    end
  endtask
  task bus(input logic w, input logic [31:0] a, input logic [31:0] d);
    htrans <= `HTRANS_NONSEQ; haddr <= a; hwrite <= w; hsel <= 1'b1;
    do @(posedge clock); while (hreadyout !== 1'b1);
    htrans <= 2'h0; hsel <= 1'b0; hwdata <= d;
    do @(posedge clock); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask
  task rd(input string n, input logic [31:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(n, exp, q);
  endtask
  task pulse;
    one_second_pulse <= 1'b1;
    repeat (3) @(posedge clock);
    one_second_pulse <= 1'b0;
    repeat (6) @(posedge clock);
  endtask
  task t_reset;
    chk("irq", 32'h0, {31'h0, irq});
    alarms <= '1;
    repeat (10) @(posedge clock);
    rd("h4", 32'h194, 32'h0);
    rd("persist", 32'h198, 32'h0);
    rd("mask", 32'h1C8, 32'h0);
    rd("unmapped", 32'h200, 32'h0);
    alarms <= '0;
  endtask
  task t_second;
    pulse;
    alarms.oom[2] <= 1'b1; alarms.lom[0] <= 1'b1; alarms.upstream_ais[1] <= 1'b1;
    @(posedge clock);
    alarms.lom[0] <= 1'b0;
    pulse; rd("h4", 32'h194, 32'h21);
    pulse; rd("h4", 32'h194, 32'h20);
    rd("persist", 32'h198, 32'h00);
    alarms.parity <= 1'b1;
    pulse; rd("persist", 32'h198, 32'h0A);
    alarms.clock_loss <= 1'b1;
    @(posedge clock);
    alarms.clock_loss <= 1'b0;
    pulse; rd("persist", 32'h198, 32'h09);
    chk("irq", 32'h0, {31'h0, irq});
    rd("status", 32'h1C4, 32'h1);
  endtask
  task t_ro;
    bus(1'b1, 32'h194, 32'hFF); bus(1'b1, 32'h198, 32'hFF);
    rd("h4", 32'h194, 32'h20);
    rd("persist", 32'h198, 32'h09);
  endtask
  task t_irq;
    bus(1'b1, 32'h1C4, 32'h3); bus(1'b1, 32'h1C8, 32'h1);
    pulse; chk("irq", 32'h1, {31'h0, irq});
    rd("status", 32'h1C4, 32'h1);
    bus(1'b1, 32'h1C4, 32'h1);
    repeat (2) @(posedge clock);
    chk("irq", 32'h0, {31'h0, irq});
    bus(1'b1, 32'h1C8, 32'h0);
    pulse; chk("irq", 32'h0, {31'h0, irq});
    rd("status", 32'h1C4, 32'h1);
  endtask
  task t_vc4;
    bus(1'b1, 32'h1C0, 32'h1);
    alarms <= '1;
    pulse; pulse; rd("h4", 32'h194, 32'h09);
    bus(1'b1, 32'h1C0, 32'h0);
  endtask
  task t_lost;
    bus(1'b1, 32'h1C4, 32'h3); bus(1'b1, 32'h1C8, 32'h2);
    repeat (TMO + 20) @(posedge clock);
    rd("h4", 32'h194, 32'h0);
    rd("persist", 32'h198, 32'h0);
    rd("status", 32'h1C4, 32'h2);
    chk("irq", 32'h1, {31'h0, irq});
  endtask
  initial begin
    repeat (4) @(posedge clock);
    rstn <= 1'b1;
    @(posedge clock);
    t_reset; t_second; t_ro; t_irq; t_vc4; t_lost;
    close_out;
  end
  initial begin
    repeat (3000) @(posedge clock);
    err_total++;
    close_out;
  end
endmodule
